// file: acrm_pkg.sv
// Shared constants and types for the audio clock rate monitor
package acrm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLK_HZ = 200_000_000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int MISS_NS = 4000;
    localparam int MISS_CYC = MISS_NS / CLK_PERIOD_NS;
    localparam int RANGE_WIN_NS = 20000;
    localparam int RANGE_WIN_CYC = RANGE_WIN_NS / CLK_PERIOD_NS;
    localparam int BCLK_MIN_KHZ = 256;
    localparam int BCLK_MAX_KHZ = 50_000;
    localparam int RANGE_MIN_EDGES = (BCLK_MIN_KHZ * RANGE_WIN_NS) / 1_000_000;
    localparam int RANGE_MAX_EDGES = (BCLK_MAX_KHZ * RANGE_WIN_NS) / 1_000_000;
    localparam int RATE_TOL_SHIFT = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices and byte addresses
    localparam int IDX_RATE_CFG = 'h28;
    localparam int IDX_CHECK_MASK = 'h29;
    localparam int IDX_RATE_MODE = 'h2A;
    localparam int IDX_REPORT = 'h2B;
    localparam int IDX_OUT_SRC = 'h30;
    localparam logic [7:0] ADDR_RATE_CFG = 8'(IDX_RATE_CFG * 4);
    localparam logic [7:0] ADDR_CHECK_MASK = 8'(IDX_CHECK_MASK * 4);
    localparam logic [7:0] ADDR_RATE_MODE = 8'(IDX_RATE_MODE * 4);
    localparam logic [7:0] ADDR_REPORT = 8'(IDX_REPORT * 4);
    localparam logic [7:0] ADDR_OUT_SRC = 8'(IDX_OUT_SRC * 4);
    localparam logic [7:0] RST_REG = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions (mask and report share positions)
    localparam int RATIO_HI = 7;
    localparam int RATIO_LO = 4;
    localparam int MANUAL_BIT = 3;
    localparam int BIT_PLL = 6;
    localparam int BIT_RANGE = 5;
    localparam int BIT_RATE = 4;
    localparam int BIT_RATIO = 3;
    localparam int BIT_MISS = 2;
    localparam int BIT_CLKERR = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Bit clocks per frame
    localparam int FRAME_CNT_W = 11;
    localparam int FS_MIN = 32;
    localparam int FS_MAX = 512;
    localparam logic [3:0] RATIO_NONE = 4'h0;
    localparam logic [3:0] RATIO_32 = 4'h3;
    localparam logic [3:0] RATIO_64 = 4'h5;
    localparam logic [3:0] RATIO_128 = 4'h7;
    localparam logic [3:0] RATIO_256 = 4'h9;
    localparam logic [3:0] RATIO_512 = 4'hB;

    ////////////////////////////////////////////////////////////////////////////
    // Sampling rate modes and rates
    typedef enum logic [3:0] {
        MODE_AUTO = 4'h0,
        MODE_32K = 4'h6,
        MODE_44K1 = 4'h8,
        MODE_48K = 4'h9,
        MODE_88K2 = 4'hA,
        MODE_96K = 4'hB,
        MODE_176K4 = 4'hC,
        MODE_192K = 4'hD
    } acrm_mode_t;
    localparam int FS_32K = 32000;
    localparam int FS_44K1 = 44100;
    localparam int FS_48K = 48000;
    localparam int FS_88K2 = 88200;
    localparam int FS_96K = 96000;
    localparam int FS_176K4 = 176400;
    localparam int FS_192K = 192000;
    localparam int PERIOD_W = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic frame_tog;
        logic bit_tog;
        logic [FRAME_CNT_W-1:0] frame_bits;
    } acrm_link_t;

    typedef struct packed {
        logic pll;
        logic range;
        logic rate;
        logic ratio;
        logic missing;
    } acrm_err_t;

endpackage

// file: acrm_sync.sv
// Two-flop level synchroniser
`timescale 1ns/100ps
module acrm_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Level in and out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // acrm_sync

// file: acrm_link_meter.sv
// Bit clock domain: counts bit clocks per frame and toggles on events
`timescale 1ns/100ps
module acrm_link_meter (
    // Link clock and reset
    input wire logic bit_clk,
    input wire logic reset_n,
    // Frame clock pin
    input wire logic frame_clk,
    // Toward the register clock domain
    output acrm_pkg::acrm_link_t link
);
    localparam logic [acrm_pkg::FRAME_CNT_W-1:0] CNT_ONE = 11'h001;
    localparam logic [acrm_pkg::FRAME_CNT_W-1:0] CNT_SAT = 11'h7FF;

    logic frame_s;
    logic frame_d_reg;
    logic [acrm_pkg::FRAME_CNT_W-1:0] cnt_reg;
    wire frame_rise = frame_s & ~frame_d_reg;

    acrm_sync #(.WIDTH(1)) u_frame_sync (
        .clk(bit_clk),
        .reset_n(reset_n),
        .async_in(frame_clk),
        .sync_out(frame_s)
    );

    always_ff @(posedge bit_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_d_reg <= 1'b0;
            cnt_reg <= CNT_ONE;
            link <= '0;
        end else begin
            frame_d_reg <= frame_s;
            link.bit_tog <= ~link.bit_tog;
            if (frame_rise) begin
                cnt_reg <= CNT_ONE;
                link.frame_bits <= cnt_reg;
                link.frame_tog <= ~link.frame_tog;
            end else if (cnt_reg != CNT_SAT) begin
                cnt_reg <= cnt_reg + CNT_ONE;
            end
        end
    end
endmodule // acrm_link_meter

// file: acrm_top.sv
// Audio clock rate monitor with APB register access
//
// Summary of operation
// R1: Measure bit clocks per frame; report code 3/5/7/9/B for 32..512.
// R2: Config register: ratio in bits 7-4, mode control bit 3, 2-0 reserved.
// R3: Mode 0000 auto-detects; software sets mode for 44.1 family rates.
// R4: Manual modes 6=32k, 8=44.1k, 9=48k, up to 192k; others reserved.
// R5: Flag PLL overrate when the PLL reaches its maximum frequency.
// R6: Mask bit 6 stops PLL overrate from raising clock error.
// R7: Flag bit clock range error when outside 256 kHz to 50 MHz.
// R8: Mask bit 5 stops range error from raising clock error.
// R9: Mask bit 4 stops rate error from clock error; report still shows it.
// R10: Flag error when bit clocks per frame fall outside 32 to 512.
// R11: Mask bit 3 stops ratio error from raising clock error.
// R12: Detect missing bit clock; mask bit 2 stops it raising clock error.
// R13: Clock error is OR of unmasked errors; masks reset to zero.
`timescale 1ns/100ps
module acrm_top #(
    parameter int CLK_HZ = acrm_pkg::CLK_HZ,
    parameter int RANGE_WIN_CYC = acrm_pkg::RANGE_WIN_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Audio clocks from host
    input wire logic bit_clk,
    input wire logic frame_clk,
    // PLL overrate level from PLL monitor
    input wire logic pll_fast,
    // Results
    output logic clock_error,
    output logic serial_output_source
);
    localparam logic [acrm_pkg::PERIOD_W-1:0] PER_ONE = 16'h0001;
    localparam logic [acrm_pkg::PERIOD_W-1:0] PER_SAT = 16'hFFFF;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    ////////////////////////////////////////////////////////////////////////////
    // Link domain and crossing
    acrm_pkg::acrm_link_t link;
    logic [2:0] sync_bus;
    logic frame_tog_d_reg;
    logic bit_tog_d_reg;

    acrm_link_meter u_link (
        .bit_clk(bit_clk),
        .reset_n(reset_n),
        .frame_clk(frame_clk),
        .link(link)
    );

    acrm_sync #(.WIDTH(3)) u_sync (
        .clk(ref_clk),
        .reset_n(reset_n),
        .async_in({pll_fast, link.frame_tog, link.bit_tog}),
        .sync_out(sync_bus)
    );

    wire pll_s = sync_bus[2];
    wire frame_seen = sync_bus[1] ^ frame_tog_d_reg;
    wire bit_seen = sync_bus[0] ^ bit_tog_d_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [3:0] ratio_reg;
    logic manual_reg;
    logic [4:0] mask_reg;
    logic [3:0] mode_reg;
    logic out_src_reg;
    acrm_pkg::acrm_err_t err_reg;
    logic [acrm_pkg::FRAME_CNT_W-1:0] cap_reg;
    logic cap_new_reg;
    logic [acrm_pkg::PERIOD_W-1:0] per_cnt_reg;
    logic [acrm_pkg::PERIOD_W-1:0] per_reg;
    logic per_new_reg;
    logic [15:0] miss_cnt_reg;
    logic [15:0] win_cnt_reg;
    logic [15:0] edge_cnt_reg;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pready & pwrite;
    wire rd_en = psel & penable & pready & ~pwrite;
    wire hit_cfg = paddr == acrm_pkg::ADDR_RATE_CFG;
    wire hit_mask = paddr == acrm_pkg::ADDR_CHECK_MASK;
    wire hit_mode = paddr == acrm_pkg::ADDR_RATE_MODE;
    wire hit_rep = paddr == acrm_pkg::ADDR_REPORT;
    wire hit_src = paddr == acrm_pkg::ADDR_OUT_SRC;
    wire hit_any = hit_cfg | hit_mask | hit_mode | hit_rep | hit_src;

    wire [4:0] err_vec = {err_reg.pll, err_reg.range, err_reg.rate, err_reg.ratio,
        err_reg.missing};
    wire err_unmasked = |(err_vec & ~mask_reg); // R13 R6 R8 R9 R11 R12
    wire [7:0] cfg_rd = {ratio_reg, manual_reg, 3'h0}; // R2
    wire [7:0] mask_rd = {1'b0, mask_reg, 2'h0};
    wire [7:0] rep_rd = {1'b0, err_vec, 1'b0, clock_error}; // R9
    wire [7:0] rd_mux = hit_cfg ? cfg_rd :
        hit_mask ? mask_rd :
        hit_mode ? {4'h0, mode_reg} :
        hit_rep ? rep_rd :
        hit_src ? {7'h00, out_src_reg} : 8'h00;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~hit_any;
            prdata <= setup & ~pwrite ? {24'h000000, rd_mux} : 32'h00000000;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            manual_reg <= 1'b0;
            mask_reg <= 5'h00; // R13
            mode_reg <= 4'h0;
            out_src_reg <= 1'b0;
        end else if (wr_en) begin
            if (hit_cfg) manual_reg <= pwdata[acrm_pkg::MANUAL_BIT];
            if (hit_mask) mask_reg <= pwdata[acrm_pkg::BIT_PLL:acrm_pkg::BIT_MISS];
            if (hit_mode) mode_reg <= pwdata[3:0];
            if (hit_src) out_src_reg <= pwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bits per frame: code and band check
    wire [3:0] ratio_code = cap_reg == 11'd32 ? acrm_pkg::RATIO_32 :
        cap_reg == 11'd64 ? acrm_pkg::RATIO_64 :
        cap_reg == 11'd128 ? acrm_pkg::RATIO_128 :
        cap_reg == 11'd256 ? acrm_pkg::RATIO_256 :
        cap_reg == 11'd512 ? acrm_pkg::RATIO_512 : acrm_pkg::RATIO_NONE; // R1
    wire ratio_bad = cap_reg < 11'(acrm_pkg::FS_MIN) ||
        cap_reg > 11'(acrm_pkg::FS_MAX); // R10

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_tog_d_reg <= 1'b0;
            bit_tog_d_reg <= 1'b0;
            cap_reg <= '0;
            cap_new_reg <= 1'b0;
            ratio_reg <= 4'h0;
        end else begin
            frame_tog_d_reg <= sync_bus[1];
            bit_tog_d_reg <= sync_bus[0];
            cap_new_reg <= frame_seen;
            if (frame_seen) cap_reg <= link.frame_bits;
            if (cap_new_reg) begin
                ratio_reg <= ratio_code; // R1
            end else if (wr_en && hit_cfg) begin
                ratio_reg <= pwdata[acrm_pkg::RATIO_HI:acrm_pkg::RATIO_LO]; // R2
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame period and sample rate check
    function automatic logic near(input logic [15:0] per, input int hz);
        int exp_p;
        int diff;
        exp_p = CLK_HZ / hz;
        diff = int'(per) - exp_p;
        if (diff < 0) diff = -diff;
        return diff <= (exp_p >>> acrm_pkg::RATE_TOL_SHIFT);
    endfunction

    wire auto_mode = !manual_reg || mode_reg == acrm_pkg::MODE_AUTO; // R3
    wire auto_ok = near(per_reg, acrm_pkg::FS_32K) | near(per_reg, acrm_pkg::FS_48K) |
        near(per_reg, acrm_pkg::FS_96K) | near(per_reg, acrm_pkg::FS_192K); // R3
    logic manual_ok;
    always_comb begin
        unique case (mode_reg) // R4
            acrm_pkg::MODE_32K: manual_ok = near(per_reg, acrm_pkg::FS_32K);
            acrm_pkg::MODE_44K1: manual_ok = near(per_reg, acrm_pkg::FS_44K1);
            acrm_pkg::MODE_48K: manual_ok = near(per_reg, acrm_pkg::FS_48K);
            acrm_pkg::MODE_88K2: manual_ok = near(per_reg, acrm_pkg::FS_88K2);
            acrm_pkg::MODE_96K: manual_ok = near(per_reg, acrm_pkg::FS_96K);
            acrm_pkg::MODE_176K4: manual_ok = near(per_reg, acrm_pkg::FS_176K4);
            acrm_pkg::MODE_192K: manual_ok = near(per_reg, acrm_pkg::FS_192K);
            default: manual_ok = 1'b0;
        endcase
    end
    wire rate_bad = (auto_mode ? !auto_ok : !manual_ok) || per_cnt_reg == PER_SAT;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            per_cnt_reg <= PER_ONE;
            per_reg <= '0;
            per_new_reg <= 1'b0;
        end else begin
            per_new_reg <= frame_seen;
            if (frame_seen) begin
                per_reg <= per_cnt_reg;
                per_cnt_reg <= PER_ONE;
            end else if (per_cnt_reg != PER_SAT) begin
                per_cnt_reg <= per_cnt_reg + PER_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit clock missing and range window
    wire win_end = win_cnt_reg == 16'(RANGE_WIN_CYC - 1);
    wire range_bad = edge_cnt_reg < 16'(acrm_pkg::RANGE_MIN_EDGES) ||
        edge_cnt_reg > 16'(acrm_pkg::RANGE_MAX_EDGES); // R7
    wire miss_now = miss_cnt_reg >= 16'(acrm_pkg::MISS_CYC); // R12

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            miss_cnt_reg <= 16'h0000;
            win_cnt_reg <= 16'h0000;
            edge_cnt_reg <= 16'h0000;
        end else begin
            if (bit_seen) miss_cnt_reg <= 16'h0000;
            else if (!miss_now) miss_cnt_reg <= miss_cnt_reg + CNT_ONE;
            win_cnt_reg <= win_end ? 16'h0000 : win_cnt_reg + CNT_ONE;
            if (win_end) edge_cnt_reg <= {15'h0000, bit_seen};
            else if (bit_seen) edge_cnt_reg <= edge_cnt_reg + CNT_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error flags and combined clock error
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            err_reg <= '0;
            clock_error <= 1'b0;
            serial_output_source <= 1'b0;
        end else begin
            err_reg.pll <= pll_s; // R5
            if (win_end) err_reg.range <= range_bad; // R7
            if (per_new_reg || per_cnt_reg == PER_SAT) err_reg.rate <= rate_bad;
            if (cap_new_reg) err_reg.ratio <= ratio_bad; // R10
            err_reg.missing <= miss_now; // R12
            clock_error <= err_unmasked; // R13
            serial_output_source <= out_src_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    ratio_code_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
        cap_new_reg && cap_reg == 11'd64 |=> ratio_reg == acrm_pkg::RATIO_64)
        else $error("ratio code not 64 per frame");

    cfg_layout_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
        setup && !pwrite && hit_cfg |=> prdata[2:0] == 3'h0 &&
        prdata[7:4] == $past(ratio_reg) && prdata[3] == $past(manual_reg))
        else $error("config readback layout wrong");

    manual_bad_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R4
        per_new_reg && manual_reg && mode_reg == 4'h4 |=> err_reg.rate)
        else $error("reserved mode gave no rate error");

    pll_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
        pll_fast [*3] |=> err_reg.pll)
        else $error("pll overrate not flagged");

    pll_mask_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R6
        mask_reg[4] && err_vec[4] && (err_vec & ~mask_reg) == 5'h00 |=> !clock_error)
        else $error("masked pll overrate raised clock error");

    range_low_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R7
        win_end && edge_cnt_reg < 16'(acrm_pkg::RANGE_MIN_EDGES) |=> err_reg.range)
        else $error("slow bit clock not flagged");

    range_mask_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R8
        mask_reg[3] && err_vec[3] && (err_vec & ~mask_reg) == 5'h00 |=> !clock_error)
        else $error("masked range error raised clock error");

    rate_report_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R9
        setup && !pwrite && hit_rep && err_reg.rate |=> prdata[acrm_pkg::BIT_RATE])
        else $error("rate error missing from report");

    ratio_band_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R10
        cap_new_reg && (cap_reg < 11'd32 || cap_reg > 11'd512) |=>
        err_reg.ratio ##1 (clock_error || $past(mask_reg[1])))
        else $error("ratio outside band not flagged");

    ratio_mask_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R11
        mask_reg[1] && err_vec[1] && (err_vec & ~mask_reg) == 5'h00 |=> !clock_error)
        else $error("masked ratio error raised clock error");

    missing_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R12
        miss_cnt_reg == 16'(acrm_pkg::MISS_CYC - 1) && !bit_seen |=> ##1 err_reg.missing)
        else $error("missing bit clock not flagged");

    mask_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
        $rose(reset_n) |-> mask_reg == 5'h00)
        else $error("masks not zero after reset");

    clkerr_or_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
        (err_vec & ~mask_reg) == 5'h00 [*2] |=> !clock_error)
        else $error("clock error with all errors masked");

    clkerr_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
        (err_vec & ~mask_reg) != 5'h00 |=> clock_error)
        else $error("unmasked error gave no clock error");

    rate_mask_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R9
        mask_reg[2] && err_vec[2] && (err_vec & ~mask_reg) == 5'h00 |=> !clock_error)
        else $error("masked rate error raised clock error");

    miss_mask_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R12
        mask_reg[0] && err_vec[0] && (err_vec & ~mask_reg) == 5'h00 |=> !clock_error)
        else $error("masked missing clock raised clock error");

    ratio_in_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R10
        cap_new_reg && (cap_reg == 11'd32 || cap_reg == 11'd512) |=> !err_reg.ratio)
        else $error("band edge flagged as ratio error");

    ratio_512_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
        cap_new_reg && cap_reg == 11'd512 |=> ratio_reg == acrm_pkg::RATIO_512)
        else $error("ratio code not 512 per frame");

    pready_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pready |=> !pready)
        else $error("ready held longer than one cycle");

    bus_error_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        setup && !hit_any |=> pready && pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");

    cov_ratio_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        cap_new_reg && ratio_code == acrm_pkg::RATIO_256);
    cov_err_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(clock_error));
    cov_manual_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        per_new_reg && !auto_mode && manual_ok);
    cov_miss_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(err_reg.missing));
    cov_pll_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(err_reg.pll));
endmodule // acrm_top

// file: acrm_host_model.sv
// Audio host model driving the bit clock and frame clock
`timescale 1ns/100ps
module acrm_host_model (
    // Control from the bench
    input wire logic run,
    input wire logic [31:0] bits,
    // Audio clocks toward the monitor
    output logic bit_clk,
    output logic frame_clk
);
    int n;
    initial begin
        bit_clk = 1'b0;
        frame_clk = 1'b0;
        #2.3;
        forever begin
            // Bit clock stands still between frames while stopped
            wait (run === 1'b1);
            n = bits;
            for (int i = 0; i < n; i++) begin
                // Frame high for the first half, changes after the falling edge
                frame_clk = (i < n / 2);
                #15 bit_clk = 1'b1;
                #15 bit_clk = 1'b0;
            end
        end
    end
endmodule // acrm_host_model

// file: tb_top.sv
// Self-checking testbench for the audio clock rate monitor
`timescale 1ns/100ps
module tb_top;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q;} acrm_row_t;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pll_fast = 1'b0;
    logic run = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, bit_clk, frame_clk, clock_error, serial_output_source, err;
    int bits = 64;
    int error_cnt = 0;
    int checks_done = 0;
    int fs_tab[5] = '{32, 64, 128, 256, 512};
    logic [3:0] code_tab[5] = '{acrm_pkg::RATIO_32, acrm_pkg::RATIO_64, acrm_pkg::RATIO_128,
        acrm_pkg::RATIO_256, acrm_pkg::RATIO_512};
    acrm_row_t rows[7] = '{
        '{acrm_pkg::ADDR_RATE_CFG, 8'hFF, 8'hF8}, '{acrm_pkg::ADDR_CHECK_MASK, 8'hFF, 8'h7C},
        '{acrm_pkg::ADDR_RATE_MODE, 8'h06, 8'h06}, '{acrm_pkg::ADDR_RATE_MODE, 8'h08, 8'h08},
        '{acrm_pkg::ADDR_RATE_MODE, 8'h09, 8'h09}, '{acrm_pkg::ADDR_OUT_SRC, 8'hFF, 8'h01},
        '{acrm_pkg::ADDR_RATE_CFG, 8'h00, 8'h00}};

    always #2.5 ref_clk = ~ref_clk;

    acrm_top #(.RANGE_WIN_CYC(400)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bit_clk(bit_clk), .frame_clk(frame_clk),
        .pll_fast(pll_fast), .clock_error(clock_error),
        .serial_output_source(serial_output_source));

    acrm_host_model u_host (.run(run), .bits(bits), .bit_clk(bit_clk), .frame_clk(frame_clk));

    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge ref_clk);
        end
        if (n == 50) chk("pready", 32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wmask(input logic [7:0] m);
        apb(1'b1, acrm_pkg::ADDR_CHECK_MASK, m);
        repeat (12) @(posedge ref_clk);
    endtask

    task automatic report();
        apb(1'b0, acrm_pkg::ADDR_REPORT, 8'h00);
    endtask

    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        do_reset();
        chk("clock_error", 32'h0, {31'h0, clock_error});
        apb(1'b0, acrm_pkg::ADDR_CHECK_MASK, 8'h00);
        chk("mask reset", 32'h0, rd);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 8'h00);
            chk("readback", {24'h0, rows[i].q}, rd);
        end
        chk("out source", 32'h1, {31'h0, serial_output_source});
        apb(1'b0, 8'h04, 8'h00);
        chk("unmapped err", 32'h1, {31'h0, err});
        $display("Test registers done");
        wmask(8'h00);
        repeat (2000) @(posedge ref_clk);
        report();
        chk("missing+range", 32'h24, rd & 32'h24);
        chk("clock_error", 32'h1, {31'h0, clock_error});
        for (int b = 2; b <= 6; b += 2) begin
            wmask(8'h7C & ~(8'h01 << b[2:0]));
            chk("one unmasked", {31'h0, b == 2}, {31'h0, clock_error});
        end
        wmask(8'h5C);
        chk("range only", 32'h1, {31'h0, clock_error});
        pll_fast <= 1'b1;
        wmask(8'h3C);
        report();
        chk("pll report", 32'h40, rd & 32'h40);
        chk("pll error", 32'h1, {31'h0, clock_error});
        wmask(8'h7C);
        chk("pll masked", 32'h0, {31'h0, clock_error});
        pll_fast <= 1'b0;
        $display("Test masks done");
        run <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            bits = fs_tab[i];
            #(3 * fs_tab[i] * 30 + 3000);
            apb(1'b0, acrm_pkg::ADDR_RATE_CFG, 8'h00);
            chk("ratio", {24'h0, code_tab[i], 4'h0}, rd);
            report();
            chk("report", 32'h10, rd & 32'h7C);
        end
        bits = 64;
        #(3 * 64 * 30 + 3000);
        wmask(8'h6C);
        chk("rate error", 32'h1, {31'h0, clock_error});
        bits = 16;
        #(4000);
        apb(1'b0, acrm_pkg::ADDR_RATE_CFG, 8'h00);
        chk("ratio none", 32'h0, rd);
        wmask(8'h74);
        chk("ratio error", 32'h1, {31'h0, clock_error});
        wmask(8'h7C);
        chk("ratio masked", 32'h0, {31'h0, clock_error});
        bits = 189;
        #(3 * 189 * 30 + 3000);
        report();
        chk("auto 176k4", 32'h10, rd & 32'h10);
        apb(1'b1, acrm_pkg::ADDR_RATE_MODE, 8'h0C);
        apb(1'b1, acrm_pkg::ADDR_RATE_CFG, 8'h08);
        #(2 * 189 * 30);
        report();
        chk("manual 176k4", 32'h0, rd & 32'h10);
        apb(1'b1, acrm_pkg::ADDR_RATE_MODE, 8'h04);
        #(2 * 189 * 30);
        report();
        chk("reserved mode", 32'h10, rd & 32'h10);
        $display("Test link done");
        do_reset();
        apb(1'b0, acrm_pkg::ADDR_CHECK_MASK, 8'h00);
        chk("mask second reset", 32'h0, rd);
        $display("Test reset done");
        conclude();
    end

    initial begin
        #400000;
        error_cnt++;
        conclude();
    end
endmodule // tb_top
